// File: src/parallel_port_pkg.sv
// Shared constants and carrier types for the parallel port block
package parallel_port_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register offsets in the standard register file
  localparam logic [7:0] OFF_PORT_ZERO_DATA       = 8'h00;
  localparam logic [7:0] OFF_PORT_ONE_DATA        = 8'h01;
  localparam logic [7:0] OFF_PORT_TWO_DATA        = 8'h02;
  localparam logic [7:0] OFF_PORT_THREE_DATA      = 8'h03;
  localparam logic [7:0] OFF_PORT_TWO_DIRECTION   = 8'hf6;
  localparam logic [7:0] OFF_PORT_THREE_FUNCTION  = 8'hf7;
  localparam logic [7:0] OFF_PORT_ZERO_ONE_CONFIG = 8'hf8;

  // Bank in which the first port is visible
  localparam logic [3:0] BANK_STANDARD = 4'h0;

  ////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int CFG_P0_LOW_LSB  = 0;
  localparam int CFG_P1_LSB      = 3;
  localparam int CFG_P0_HIGH_LSB = 6;
  localparam int FUNC_HS0_BIT    = 2;
  localparam int FUNC_HS1_LO_BIT = 3;
  localparam int FUNC_HS1_HI_BIT = 4;

  // Fourth-port lines borrowed by the handshakes
  localparam int LINE_HS0_IN  = 2;
  localparam int LINE_HS0_OUT = 5;
  localparam int LINE_HS1_IN  = 3;
  localparam int LINE_HS1_OUT = 4;

  // Two-bit direction codes of the shared mode register
  localparam logic [1:0] MODE_OUTPUT = 2'b00;
  localparam logic [1:0] MODE_INPUT  = 2'b01;

  ////////////////////////////////////////////////////////////////////////
  // Reset values: ports zero to two all inputs, no handshake
  localparam logic [7:0] RST_PORT_DATA       = 8'h00;
  localparam logic [7:0] RST_PORT_TWO_DIR    = 8'hff;
  localparam logic [7:0] RST_PORT_THREE_FUNC = 8'h00;
  localparam logic [7:0] RST_ZERO_ONE_CONFIG = 8'h49;
  localparam logic [7:0] RST_PORT_THREE_OUT  = 8'hff;

  // Input synchroniser depth
  localparam int SYNC_STAGES = 2;

  ////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    HS_IDLE    = 2'b00,
    HS_BUSY    = 2'b01,
    HS_RELEASE = 2'b10
  } hsState_e;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } regReq_s;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oeN;
  } pinDrive_s;

endpackage

// File: src/handshake_engine.sv
// Interlocked strobe/acknowledge sequencer for one handshake port
module handshake_engine
  import parallel_port_pkg::*;
#(
  parameter int WIDTH = 8
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             enable,
  input  wire logic             inputMode,
  input  wire logic             lineIn,
  input  wire logic [WIDTH-1:0] pinData,
  input  wire logic             writePulse,
  input  wire logic             readPulse,
  output logic                  lineOut,
  output logic [WIDTH-1:0]      latched,
  output logic                  holding
);

  if (WIDTH < 1) begin : g_width_check
    $error("handshake_engine: WIDTH must be positive");
  end

  typedef struct packed {
    hsState_e         state;
    logic             lineOut;
    logic [WIDTH-1:0] latched;
    logic             full;
  } hsReg_s;

  hsReg_s q;
  hsReg_s d;

  always_comb begin
    d = q;
    if (!enable) begin
      d.state   = HS_IDLE;
      d.lineOut = 1'b1;
      d.full    = 1'b0;
    end else if (inputMode) begin
      // A read frees the latch; strobes are only taken in HS_IDLE, even in the cycle of the freeing read
      if (readPulse) d.full = 1'b0;
      case (q.state)
        HS_IDLE: begin
          d.lineOut = ~d.full;
          if (!lineIn && !d.full) begin
            d.latched = pinData;
            d.full    = 1'b1;
            d.lineOut = 1'b0;
            d.state   = HS_BUSY;
          end
        end
        HS_BUSY: begin
          if (lineIn) d.state = HS_RELEASE;
        end
        HS_RELEASE: begin
          // Ready is only raised once software has taken the byte
          if (!d.full) begin
            d.lineOut = 1'b1;
            d.state   = HS_IDLE;
          end
        end
        default: d.state = HS_IDLE;
      endcase
    end else begin
      d.full = 1'b0;
      case (q.state)
        HS_IDLE: begin
          d.lineOut = 1'b1;
          if (writePulse) begin
            d.lineOut = 1'b0;
            d.state   = HS_BUSY;
          end
        end
        HS_BUSY: begin
          // Data is unprotected: later writes simply replace it
          if (!lineIn) begin
            d.lineOut = 1'b1;
            d.state   = HS_RELEASE;
          end
        end
        HS_RELEASE: begin
          if (lineIn) d.state = HS_IDLE;
        end
        default: d.state = HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      q.state   <= HS_IDLE;
      q.lineOut <= 1'b1;
      q.latched <= '0;
      q.full    <= 1'b0;
    end else begin
      q <= d;
    end
  end

  assign lineOut = q.lineOut;
  assign latched = q.latched;
  assign holding = q.full;

endmodule

// File: src/parallel_port_handshake_io.sv
// Four general-purpose parallel ports with strobe/acknowledge handshake
//
// Functional notes
// - Writes to input bits stored, never read back
// - Output register drives pin when bit turns output
// - Pins sampled two clocks before a read
// - Port zero nibbles set by config bits 1:0, 7:6
// - Port zero at 00H in bank zero, writes store
// - Port zero output reads return pin levels
// - Handshake inputs read latched data, others pins
// - Port zero handshake when function bit 2 set
// - Port zero strobe/ack on lines 2 and 5
// - Upper nibble sets direction; lower joins if equal
// - Port one byte set by config bits 4:3
// - Port one at 01H, output reads show pins
// - Port one handshake when function bits 4,3 set
// - Port one strobe/ack on lines 3 and 4
// - Port one handshake direction follows its byte mode
// - Port two direction per bit, 1 is input
// - Port and mode registers are ordinary registers
// - First input strobe latches, held until read
// - Active-low strobe, acknowledge signals receipt and ready
// - Output writes during handshake replace pending data
module parallel_port_handshake_io
  import parallel_port_pkg::*;
#(
  parameter int PORT_WIDTH = 8
) (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  regReq_s         regReq,
  input  wire logic [3:0] expandedRegisterBank,
  output logic [7:0]      regRdata,
  input  wire logic [7:0] portZeroIn,
  input  wire logic [7:0] portOneIn,
  input  wire logic [7:0] portTwoIn,
  input  wire logic [7:0] portThreeIn,
  output pinDrive_s       portZeroPins,
  output pinDrive_s       portOnePins,
  output pinDrive_s       portTwoPins,
  output pinDrive_s       portThreePins
);

  // The register layout fixes the port width and the port three line split
  if (PORT_WIDTH != 8) begin : g_width_check
    $error("parallel_port_handshake_io: ports are eight bits wide");
  end

  // The capture path is built as exactly two flip-flops
  if (SYNC_STAGES != 2) begin : g_sync_check
    $error("parallel_port_handshake_io: synchroniser depth must be two");
  end

  // Handshake inputs sit on the input half of port three, outputs on the driven half
  if (LINE_HS0_IN > 3 || LINE_HS1_IN > 3) begin : g_line_in_check
    $error("parallel_port_handshake_io: handshake inputs must be lines 3:0");
  end
  if (LINE_HS0_OUT < 4 || LINE_HS1_OUT < 4) begin : g_line_out_check
    $error("parallel_port_handshake_io: handshake outputs must be lines 7:4");
  end

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Direction codes 1x select the external-memory modes, which are not built
  function automatic logic isIoMode(input logic [1:0] mode);
    isIoMode = (mode == MODE_INPUT) || (mode == MODE_OUTPUT);
  endfunction

  function automatic logic isInput(input logic [1:0] mode);
    isInput = (mode == MODE_INPUT);
  endfunction

  // Output enable is low only for a nibble or byte in output mode
  function automatic logic [3:0] nibbleOeN(input logic [1:0] mode);
    nibbleOeN = (mode == MODE_OUTPUT) ? 4'h0 : 4'hf;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [7:0]  portZeroOut;
    logic [7:0]  portOneOut;
    logic [7:0]  portTwoOut;
    logic [7:0]  portThreeOut;
    logic [7:0]  portTwoDirection;
    logic [7:0]  portThreeFunction;
    logic [7:0]  portZeroOneConfig;
    logic [31:0] syncFirst;
    logic [31:0] syncSecond;
    logic [7:0]  rdata;
    pinDrive_s   zeroDrive;
    pinDrive_s   oneDrive;
    pinDrive_s   twoDrive;
    pinDrive_s   threeDrive;
  } portReg_s;

  portReg_s q;
  portReg_s d;

  ////////////////////////////////////////////////////////////////////////
  // Decode and mode derivation

  logic [1:0] zeroLowMode;
  logic [1:0] zeroHighMode;
  logic [1:0] oneMode;
  logic       hs0Enable;
  logic       hs0Input;
  logic       hs0LowJoins;
  logic       hs1Enable;
  logic       hs1Input;
  logic       wrZero;
  logic       rdZero;
  logic       wrOne;
  logic       rdOne;
  logic [7:0] syncZero;
  logic [7:0] syncOne;
  logic [7:0] syncTwo;
  logic [7:0] syncThree;
  logic       hs0Line;
  logic       hs1Line;
  logic [7:0] hs0Latched;
  logic [7:0] hs1Latched;

  assign zeroLowMode  = q.portZeroOneConfig[CFG_P0_LOW_LSB +: 2];
  assign zeroHighMode = q.portZeroOneConfig[CFG_P0_HIGH_LSB +: 2];
  assign oneMode      = q.portZeroOneConfig[CFG_P1_LSB +: 2];

  // Handshake enables and directions
  assign hs0Enable   = q.portThreeFunction[FUNC_HS0_BIT] && isIoMode(zeroHighMode);
  assign hs0Input    = isInput(zeroHighMode);
  assign hs0LowJoins = (zeroLowMode == zeroHighMode);
  assign hs1Enable   = q.portThreeFunction[FUNC_HS1_LO_BIT]
                    && q.portThreeFunction[FUNC_HS1_HI_BIT]
                    && isIoMode(oneMode);
  assign hs1Input    = isInput(oneMode);

  // Port zero is only visible in the standard bank
  assign wrZero = regReq.wr && (regReq.addr == OFF_PORT_ZERO_DATA)
               && (expandedRegisterBank == BANK_STANDARD);
  assign rdZero = regReq.rd && (regReq.addr == OFF_PORT_ZERO_DATA)
               && (expandedRegisterBank == BANK_STANDARD);
  assign wrOne  = regReq.wr && (regReq.addr == OFF_PORT_ONE_DATA);
  assign rdOne  = regReq.rd && (regReq.addr == OFF_PORT_ONE_DATA);

  // Second synchroniser stage is the input register of every port
  assign syncZero  = q.syncSecond[7:0];
  assign syncOne   = q.syncSecond[15:8];
  assign syncTwo   = q.syncSecond[23:16];
  assign syncThree = q.syncSecond[31:24];

  ////////////////////////////////////////////////////////////////////////
  // Handshake sequencers

  handshake_engine #(
    .WIDTH (8)
  ) hsZero (
    .clock      (clock),
    .reset_n    (reset_n),
    .enable     (hs0Enable),
    .inputMode  (hs0Input),
    .lineIn     (syncThree[LINE_HS0_IN]),
    .pinData    (syncZero),
    .writePulse (wrZero),
    .readPulse  (rdZero),
    .lineOut    (hs0Line),
    .latched    (hs0Latched),
    .holding    ()
  );

  handshake_engine #(
    .WIDTH (8)
  ) hsOne (
    .clock      (clock),
    .reset_n    (reset_n),
    .enable     (hs1Enable),
    .inputMode  (hs1Input),
    .lineIn     (syncThree[LINE_HS1_IN]),
    .pinData    (syncOne),
    .writePulse (wrOne),
    .readPulse  (rdOne),
    .lineOut    (hs1Line),
    .latched    (hs1Latched),
    .holding    ()
  );

  ////////////////////////////////////////////////////////////////////////
  // Next state

  logic [7:0] zeroRead;
  logic [7:0] oneRead;
  logic [7:0] threePinOut;

  always_comb begin
    d = q;

    // Two-stage capture keeps metastable pins away from reads
    d.syncFirst  = {portThreeIn, portTwoIn, portOneIn, portZeroIn};
    d.syncSecond = q.syncFirst;

    // Port zero read: pins, or latched data for handshake inputs
    zeroRead = syncZero;
    if (hs0Enable && hs0Input) begin
      zeroRead[7:4] = hs0Latched[7:4];
      if (hs0LowJoins) zeroRead[3:0] = hs0Latched[3:0];
    end

    oneRead = syncOne;
    if (hs1Enable && hs1Input) oneRead = hs1Latched;

    // Register writes; stores happen whatever the direction
    if (regReq.wr) begin
      if (wrZero) begin
        d.portZeroOut = regReq.wdata;
      end else if (regReq.addr == OFF_PORT_ONE_DATA) begin
        d.portOneOut = regReq.wdata;
      end else if (regReq.addr == OFF_PORT_TWO_DATA) begin
        d.portTwoOut = regReq.wdata;
      end else if (regReq.addr == OFF_PORT_THREE_DATA) begin
        d.portThreeOut = regReq.wdata;
      end else if (regReq.addr == OFF_PORT_TWO_DIRECTION) begin
        d.portTwoDirection = regReq.wdata;
      end else if (regReq.addr == OFF_PORT_THREE_FUNCTION) begin
        d.portThreeFunction = regReq.wdata;
      end else if (regReq.addr == OFF_PORT_ZERO_ONE_CONFIG) begin
        d.portZeroOneConfig = regReq.wdata;
      end
    end

    // Register reads; unmapped offsets answer zero
    if (regReq.rd) begin
      if (rdZero) begin
        d.rdata = zeroRead;
      end else if (regReq.addr == OFF_PORT_ONE_DATA) begin
        d.rdata = oneRead;
      end else if (regReq.addr == OFF_PORT_TWO_DATA) begin
        d.rdata = syncTwo;
      end else if (regReq.addr == OFF_PORT_THREE_DATA) begin
        d.rdata = {q.threeDrive.out[7:4], syncThree[3:0]};
      end else if (regReq.addr == OFF_PORT_TWO_DIRECTION) begin
        d.rdata = q.portTwoDirection;
      end else if (regReq.addr == OFF_PORT_THREE_FUNCTION) begin
        d.rdata = q.portThreeFunction;
      end else if (regReq.addr == OFF_PORT_ZERO_ONE_CONFIG) begin
        d.rdata = q.portZeroOneConfig;
      end else begin
        d.rdata = 8'h00;
      end
    end

    // Pin drivers follow the new register values, so a preset output
    // appears on the pin in the same edge that turns it around
    d.zeroDrive.out = d.portZeroOut;
    d.zeroDrive.oeN = {nibbleOeN(d.portZeroOneConfig[CFG_P0_HIGH_LSB +: 2]),
                       nibbleOeN(d.portZeroOneConfig[CFG_P0_LOW_LSB +: 2])};
    d.oneDrive.out  = d.portOneOut;
    d.oneDrive.oeN  = {2{nibbleOeN(d.portZeroOneConfig[CFG_P1_LSB +: 2])}};
    d.twoDrive.out  = d.portTwoOut;
    d.twoDrive.oeN  = d.portTwoDirection;

    // Handshake outputs take over their lines; software writes there are
    // kept in the register but never reach the pin
    threePinOut = d.portThreeOut;
    if (hs0Enable) threePinOut[LINE_HS0_OUT] = hs0Line;
    if (hs1Enable) threePinOut[LINE_HS1_OUT] = hs1Line;
    d.threeDrive.out = {threePinOut[7:4], 4'h0};
    d.threeDrive.oeN = 8'h0f;
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      q.portZeroOut       <= RST_PORT_DATA;
      q.portOneOut        <= RST_PORT_DATA;
      q.portTwoOut        <= RST_PORT_DATA;
      q.portThreeOut      <= RST_PORT_THREE_OUT;
      q.portTwoDirection  <= RST_PORT_TWO_DIR;
      q.portThreeFunction <= RST_PORT_THREE_FUNC;
      q.portZeroOneConfig <= RST_ZERO_ONE_CONFIG;
      q.syncFirst         <= 32'h0000_0000;
      q.syncSecond        <= 32'h0000_0000;
      q.rdata             <= 8'h00;
      q.zeroDrive         <= {RST_PORT_DATA, 8'hff};
      q.oneDrive          <= {RST_PORT_DATA, 8'hff};
      q.twoDrive          <= {RST_PORT_DATA, RST_PORT_TWO_DIR};
      q.threeDrive        <= {RST_PORT_THREE_OUT[7:4], 4'h0, 8'h0f};
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign regRdata      = q.rdata;
  assign portZeroPins  = q.zeroDrive;
  assign portOnePins   = q.oneDrive;
  assign portTwoPins   = q.twoDrive;
  assign portThreePins = q.threeDrive;

endmodule

// File: tb/port_io_asserts.sv
// Concurrent checks on the parallel port block's ports
module port_io_asserts
  import parallel_port_pkg::*;
(
  input wire logic       clock,
  input wire logic       reset_n,
  input regReq_s         regReq,
  input wire logic [3:0] expandedRegisterBank,
  input wire logic [7:0] regRdata,
  input wire logic [7:0] portTwoIn,
  input wire logic [7:0] portThreeIn,
  input pinDrive_s       portZeroPins,
  input pinDrive_s       portOnePins,
  input pinDrive_s       portTwoPins,
  input pinDrive_s       portThreePins
);
  default clocking cbk @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire logic cfgWr  = regReq.wr && regReq.addr == OFF_PORT_ZERO_ONE_CONFIG;
  wire logic oneWr  = regReq.wr && regReq.addr == OFF_PORT_ONE_DATA;
  wire logic bankOk = expandedRegisterBank == BANK_STANDARD;
  ////////////////////////////////////////////////////////////////////////
  a_bank_read_blank: assert property (regReq.rd && regReq.addr == 8'h00 && !bankOk
    |=> regRdata == 8'h00) else $error("port zero read outside bank zero");
  a_zero_write_drives: assert property (regReq.wr && regReq.addr == 8'h00 && bankOk
    |=> ((portZeroPins.out ^ $past(regReq.wdata)) & ~portZeroPins.oeN) == 8'h00)
    else $error("port zero write missing on driven pins");
  a_zero_nibble_cfg: assert property (cfgWr |=> portZeroPins.oeN ==
    {{4{$past(regReq.wdata[7:6]) != MODE_OUTPUT}},
     {4{$past(regReq.wdata[1:0]) != MODE_OUTPUT}}}) else $error("port zero direction");
  a_one_byte_cfg: assert property (cfgWr |=> portOnePins.oeN ==
    {8{$past(regReq.wdata[4:3]) != MODE_OUTPUT}}) else $error("port one direction");
  a_two_dir_bits: assert property (regReq.wr && regReq.addr == 8'hf6
    |=> portTwoPins.oeN == $past(regReq.wdata)) else $error("port two direction");
  a_input_two_sync: assert property (regReq.rd && regReq.addr == 8'h02
    && portTwoPins.oeN == 8'hff |=> regRdata == $past(portTwoIn, 3))
    else $error("port two read not two clocks old");
  a_ack_after_strobe: assert property ($fell(portThreePins.out[LINE_HS0_OUT])
    |-> !$past(portThreeIn[LINE_HS0_IN], 2)) else $error("ack without strobe");
  a_strobe_after_write: assert property ($fell(portThreePins.out[LINE_HS1_OUT])
    |-> $past(oneWr) || $past(oneWr, 2) || $past(oneWr, 3))
    else $error("strobe without write");
  c_ack: cover property ($fell(portThreePins.out[LINE_HS0_OUT]));
  c_strobe: cover property ($fell(portThreePins.out[LINE_HS1_OUT]));
  c_refused: cover property (regReq.rd && regReq.addr == 8'h00 && !bankOk);
endmodule

// File: tb/handshake_peer.sv
// Behavioural peripheral on the far side of the two handshake ports
module handshake_peer (
  input  wire logic       clock,
  input  wire logic       ackZero,
  input  wire logic       strobeOne,
  input  wire logic [7:0] busOne,
  output logic            strobeZeroN,
  output logic            ackOneN,
  output logic [7:0]      busZero,
  output logic [7:0]      captured,
  output int              xfers,
  output logic            timedOut
);
  timeunit 1ns;
  timeprecision 100ps;
  int ackDelay;
  int n;
  initial begin
    strobeZeroN = 1'b1;
    ackOneN = 1'b1;
    busZero = 8'h00;
    captured = 8'h00;
    xfers = 0;
    timedOut = 1'b0;
    ackDelay = 0;
  end
  task automatic present(input logic [7:0] d);
    @(posedge clock);
    #1 busZero = d;
  endtask
  // Data settles a cycle ahead of the strobe and stays until ack is seen, or for five cycles when wantAck is clear
  task automatic send(input logic [7:0] d, input bit wantAck);
    int k;
    present(d);
    @(posedge clock);
    #1 strobeZeroN = 1'b0;
    for (k = 0; k < 40; k++) begin
      @(posedge clock);
      #1;
      if (wantAck ? ackZero === 1'b0 : k == 4) break;
    end
    if (k == 40) timedOut = 1'b1;
    strobeZeroN = 1'b1;
    busZero = ~d; // Released bus must not keep looking valid
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Receiver; ackDelay models a slow peripheral
  always begin
    @(negedge strobeOne);
    repeat (ackDelay) @(posedge clock);
    @(posedge clock);
    #1 captured = busOne;
    ackOneN = 1'b0;
    xfers++;
    for (n = 0; n < 40 && strobeOne !== 1'b1; n++) begin
      @(posedge clock);
      #1;
    end
    if (n == 40) timedOut = 1'b1;
    @(posedge clock);
    #1 ackOneN = 1'b1;
  end
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the parallel port block
module tb_top
  import parallel_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clock, reset_n, strobeZeroN, ackOneN, timedOut;
  regReq_s    regReq;
  logic [3:0] bank;
  logic [7:0] regRdata, extTwo, clamp, busZero, captured;
  logic [7:0] portZeroIn, portOneIn, portTwoIn, portThreeIn;
  pinDrive_s  portZeroPins, portOnePins, portTwoPins, portThreePins;
  int         xfers, errCount, samplesChecked;
  // Undriven bits show the far side; clamp mimics an open-drain line held low
  function automatic logic [7:0] pinLevel(pinDrive_s p, logic [7:0] ext, logic [7:0] pull);
    return ((p.out & ~p.oeN) | (ext & p.oeN)) & ~pull;
  endfunction
  assign portZeroIn  = pinLevel(portZeroPins, busZero, clamp);
  assign portOneIn   = pinLevel(portOnePins, ~portOnePins.out, clamp);
  assign portTwoIn   = pinLevel(portTwoPins, extTwo, 8'h00);
  assign portThreeIn = {portThreePins.out[7:4], ackOneN, strobeZeroN, 2'b11};
  parallel_port_handshake_io DUT (.clock(clock), .reset_n(reset_n), .regReq(regReq),
    .expandedRegisterBank(bank), .regRdata(regRdata), .portZeroIn(portZeroIn),
    .portOneIn(portOneIn), .portTwoIn(portTwoIn), .portThreeIn(portThreeIn),
    .portZeroPins(portZeroPins), .portOnePins(portOnePins), .portTwoPins(portTwoPins),
    .portThreePins(portThreePins));
  handshake_peer peer (.clock(clock), .ackZero(portThreePins.out[LINE_HS0_OUT]),
    .strobeOne(portThreePins.out[LINE_HS1_OUT]), .busOne(portOnePins.out),
    .strobeZeroN(strobeZeroN), .ackOneN(ackOneN), .busZero(busZero),
    .captured(captured), .xfers(xfers), .timedOut(timedOut));
  always #4 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    if (errCount == 0 && samplesChecked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      errCount++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic expire(input int k, input int lim);
    if (k >= lim || timedOut !== 1'b0) begin
      errCount++;
      $display("mismatch at %0t: wait expired", $time);
      print_verdict();
    end
  endtask
  task automatic regWrite(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1 regReq = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clock);
    #1 regReq.wr = 1'b0;
  endtask
  task automatic rdCheck(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    #1 regReq = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clock);
    #1 regReq.rd = 1'b0;
    check(regRdata, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic reset_values;
    rdCheck(OFF_PORT_ZERO_ONE_CONFIG, RST_ZERO_ONE_CONFIG);
    rdCheck(OFF_PORT_THREE_FUNCTION, RST_PORT_THREE_FUNC);
    rdCheck(OFF_PORT_TWO_DIRECTION, RST_PORT_TWO_DIR);
    rdCheck(8'h10, 8'h00);
    check(portZeroPins.oeN, 8'hff);
    rdCheck(OFF_PORT_THREE_DATA, {RST_PORT_THREE_OUT[7:4], 4'hf});
    check(portThreePins.oeN, 8'h0f);
  endtask
  task automatic preset_and_bank;
    peer.present(8'h3c);
    regWrite(OFF_PORT_ZERO_DATA, 8'ha5);
    rdCheck(OFF_PORT_ZERO_DATA, 8'h3c);
    regWrite(OFF_PORT_ZERO_ONE_CONFIG, 8'h09);
    check(portZeroPins.oeN, 8'h0f);
    check(portZeroPins.out & 8'hf0, 8'ha0);
    clamp = 8'h20;
    repeat (2) @(posedge clock);
    rdCheck(OFF_PORT_ZERO_DATA, 8'h8c);
    clamp = 8'h00;
    regWrite(OFF_PORT_ZERO_ONE_CONFIG, 8'h48);
    check(portZeroPins.oeN, 8'hf0);
    check(portZeroPins.out & 8'h0f, 8'h05);
    bank = 4'h1;
    regWrite(OFF_PORT_ZERO_DATA, 8'h00);
    rdCheck(OFF_PORT_ZERO_DATA, 8'h00);
    bank = 4'h0;
    check(portZeroPins.out & 8'h0f, 8'h05);
  endtask
  task automatic port_one_two;
    regWrite(OFF_PORT_ZERO_ONE_CONFIG, 8'h41);
    regWrite(OFF_PORT_ONE_DATA, 8'h77);
    check(portOnePins.oeN, 8'h00);
    check(portOnePins.out, 8'h77);
    clamp = 8'h01;
    repeat (2) @(posedge clock);
    rdCheck(OFF_PORT_ONE_DATA, 8'h76);
    clamp = 8'h00;
    regWrite(OFF_PORT_TWO_DIRECTION, 8'h0f);
    check(portTwoPins.oeN, 8'h0f);
    regWrite(OFF_PORT_TWO_DATA, 8'h96);
    check(portTwoPins.out, 8'h96);
    rdCheck(OFF_PORT_TWO_DIRECTION, 8'h0f);
    rdCheck(OFF_PORT_TWO_DATA, 8'h90);
    regWrite(OFF_PORT_TWO_DIRECTION, 8'hff);
    extTwo = 8'h5a;
    repeat (3) @(posedge clock);
    #1 extTwo = 8'hc3;
    rdCheck(OFF_PORT_TWO_DATA, 8'h5a);
    extTwo = 8'h81;
    @(posedge clock);
    rdCheck(OFF_PORT_TWO_DATA, 8'h81);
  endtask
  task automatic input_handshake;
    int k;
    regWrite(OFF_PORT_ZERO_ONE_CONFIG, 8'h49);
    regWrite(OFF_PORT_THREE_FUNCTION, 8'h04);
    peer.send(8'h96, 1'b1);
    expire(0, 1);
    peer.send(8'h33, 1'b0);
    check({7'h0, portThreePins.out[LINE_HS0_OUT]}, 8'h00);
    rdCheck(OFF_PORT_ZERO_DATA, 8'h96);
    for (k = 0; k < 10 && portThreePins.out[LINE_HS0_OUT] !== 1'b1; k++) begin
      @(posedge clock);
      #1;
    end
    expire(k, 10);
    regWrite(OFF_PORT_THREE_FUNCTION, 8'h00);
  endtask
  task automatic waitXfer(input int target);
    int k;
    for (k = 0; k < 60 && !(xfers == target && ackOneN === 1'b1); k++) @(posedge clock);
    expire(k, 60);
  endtask
  task automatic output_handshake;
    regWrite(OFF_PORT_ZERO_ONE_CONFIG, 8'h41);
    regWrite(OFF_PORT_THREE_FUNCTION, 8'h10);
    regWrite(OFF_PORT_ONE_DATA, 8'h3c);
    repeat (6) @(posedge clock);
    #1;
    check({7'h0, portThreePins.out[LINE_HS1_OUT]}, 8'h01);
    regWrite(OFF_PORT_THREE_FUNCTION, 8'h18);
    regWrite(OFF_PORT_ONE_DATA, 8'hc5);
    waitXfer(1);
    check(captured, 8'hc5);
    peer.ackDelay = 8;
    // Let the sequencer see ack high and go idle, so 8'h11 really opens a transfer
    repeat (4) @(posedge clock);
    regWrite(OFF_PORT_ONE_DATA, 8'h11);
    regWrite(OFF_PORT_ONE_DATA, 8'h22);
    waitXfer(2);
    check(captured, 8'h22);
  endtask
  initial begin
    clock = 1'b0;
    reset_n = 1'b0;
    regReq = '0;
    bank = 4'h0;
    extTwo = 8'h00;
    clamp = 8'h00;
    errCount = 0;
    samplesChecked = 0;
    repeat (8) @(posedge clock);
    #1 reset_n = 1'b1;
    reset_values();
    preset_and_bank();
    port_one_two();
    input_handshake();
    output_handshake();
    print_verdict();
  end
endmodule
bind parallel_port_handshake_io port_io_asserts chk (.clock(clock), .reset_n(reset_n),
  .regReq(regReq), .expandedRegisterBank(expandedRegisterBank), .regRdata(regRdata),
  .portTwoIn(portTwoIn), .portThreeIn(portThreeIn), .portZeroPins(portZeroPins),
  .portOnePins(portOnePins), .portTwoPins(portTwoPins), .portThreePins(portThreePins));
